// ### shared/pwmc_pkg.sv
// Purpose: Shared constants for the motor PWM control logic
// Assumes: Byte-wide register port, one 200 MHz clock
// Notes:   Register offsets are byte indices on the plain port
package pwmc_pkg;

    // Register offsets
    localparam logic [4:0] A_CTL1  = 5'h00;
    localparam logic [4:0] A_CTL2  = 5'h01;
    localparam logic [4:0] A_CNTH  = 5'h02;
    localparam logic [4:0] A_CNTL  = 5'h03;
    localparam logic [4:0] A_MODH  = 5'h04;
    localparam logic [4:0] A_MODL  = 5'h05;
    localparam logic [4:0] A_DUTY0 = 5'h06;
    localparam logic [4:0] A_DEAD  = 5'h12;

    // First control register fields
    localparam int B_EN   = 0;
    localparam int B_LOAD_OK = 1;
    localparam int B_FLAG = 4;
    localparam int B_IRQE = 5;
    localparam int B_BANK_Y_SOFT_DISABLE = 6;
    localparam int B_BANK_X_SOFT_DISABLE = 7;

    // Second control register fields
    localparam int B_PRSC  = 0;
    localparam int B_PAIR3_CORRECTION_SELECT = 3;
    localparam int B_PAIR2_CORRECTION_SELECT = 4;
    localparam int B_PAIR1_CORRECTION_SELECT = 5;
    localparam int B_LDFQ  = 6;

    // Values after reset
    localparam logic [7:0]  DEAD_RST = 8'h00;
    localparam logic [11:0] MOD_RST  = 12'h000;

    typedef enum logic [1:0] {
        ST_OFF  = 2'b00,
        ST_HOLD = 2'b01,
        ST_RUN  = 2'b11
    } run_st_t;

endpackage

// ### src/motor_pwm_control_logic.sv
// Purpose: Control logic of a six-channel motor PWM generator
// Assumes: All inputs come from logic on sys_clk; fault logic lives outside
// Notes:   Inactive pin level is 0; polarity handling is outside
// Operation
// - Stop mode freezes every flop of the block, outputs included.
// - Break mode freezes counter, generator and output state.
// - Fault disables still force outputs inactive during break.
// - In break, flag clears only take effect with break-clear-enable high.
// - Reading counter high byte latches low byte until low byte read.
// - Period is twice modulus center-aligned, equal to modulus edge-aligned.
// - Modulus writes go to a buffer adopted at a load-ok reload.
// - Modulus zero makes the counter count down continually from top.
// - Duty at or below zero is off; at or above modulus is on.
// - Duty values buffered; complementary pairs share value registers.
// - Bank disable acts at once; release waits for next cycle start.
// - Interrupt pending while reload flag and its enable are set.
// - Flag sets every reload; cleared by read-one then write-zero.
// - Modulus, prescaler and duty buffers transfer at reload only with load-ok, which then clears.
// - Enable clear stops generator and floats pins unless manual control.
// - Load frequency picks reload every 1, 2, 4 or 8 cycles.
// - Correction bit picks odd or even duty, applied each cycle start.
// - Prescaler divides counter clock by 1, 2, 4 or 8.
// - Nonzero prescaler delays pin drive one PWM cycle after enable.
// - Dead time in bus clocks, inserted in complementary mode, write-once.
// - Every rise of enable from clear performs an immediate reload.
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
module motor_pwm_control_logic (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    input  wire logic [4:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output      logic [7:0] rdata,
    input  wire logic       stop_mode,
    input  wire logic       break_mode,
    input  wire logic       break_clear_enable,
    input  wire logic       complementary_mode,
    input  wire logic       center_aligned,
    input  wire logic [5:0] disable_map_x,
    input  wire logic [5:0] disable_map_y,
    input  wire logic [5:0] fault_disable,
    input  wire logic       manual_output_control,
    input  wire logic [5:0] manual_out,
    output      logic [5:0] pwm_out,
    output      logic [5:0] pwm_oe,
    output      logic       reload_irq
);

    typedef struct packed {
        pwmc_pkg::run_st_t st;
        logic              en;
        logic              load_ok;
        logic              flag;
        logic              irqe;
        logic              bank_x_soft_disable;
        logic              bank_y_soft_disable;
        logic              armed;
        logic [1:0]        ldfq_b;
        logic [1:0]        ldfq_a;
        logic [1:0]        prsc_b;
        logic [1:0]        prsc_a;
        logic [2:0]        sel_b;
        logic [2:0]        sel_a;
        logic [11:0]       mod_b;
        logic [11:0]       mod_a;
        logic [11:0]       cnt;
        logic              dir_dn;
        logic [2:0]        pre_cnt;
        logic [2:0]        ld_cnt;
        logic [5:0][15:0]  duty_b;
        logic [5:0][15:0]  duty_a;
        logic [7:0]        dead;
        logic              dead_wr;
        logic [7:0]        lat;
        logic              lat_vld;
        logic [5:0]        sw_mask;
        logic [2:0][7:0]   dt_cnt;
        logic [2:0]        gen_prev;
        logic [5:0]        out;
        logic [5:0]        oe;
        logic              irq;
        logic [7:0]        rdata;
    } state_t;

    state_t      s_q;
    state_t      s_d;
    logic        clr_ok;
    logic        tick;
    logic        cyc;
    logic        reload;
    logic        en_rise;
    logic [2:0]  g;
    logic [2:0]  dt0;
    logic [5:0]  act;
    logic [5:0]  raw;
    logic [5:0]  mask;
    logic [15:0] dv;
    logic        live;

    always_comb begin
        s_d       = s_q;
        s_d.rdata = 8'h00;
        clr_ok    = !break_mode || break_clear_enable;
        tick      = 1'b0;
        cyc       = 1'b0;
        reload    = 1'b0;
        g         = 3'b000;
        dt0       = 3'b000;
        act       = 6'h00;
        raw       = 6'h00;
        mask      = 6'h00;
        dv        = 16'h0000;

        if (rd) begin
            case (addr)
                pwmc_pkg::A_CTL1: begin
                    s_d.rdata[pwmc_pkg::B_EN]   = s_q.en;
                    s_d.rdata[pwmc_pkg::B_LOAD_OK] = s_q.load_ok;
                    s_d.rdata[pwmc_pkg::B_FLAG] = s_q.flag;
                    s_d.rdata[pwmc_pkg::B_IRQE] = s_q.irqe;
                    s_d.rdata[pwmc_pkg::B_BANK_Y_SOFT_DISABLE] = s_q.bank_y_soft_disable;
                    s_d.rdata[pwmc_pkg::B_BANK_X_SOFT_DISABLE] = s_q.bank_x_soft_disable;
                    if (s_q.flag && clr_ok) begin
                        s_d.armed = 1'b1;
                    end
                end
                pwmc_pkg::A_CTL2: begin
                    s_d.rdata[pwmc_pkg::B_PRSC +: 2] = s_q.prsc_b;
                    s_d.rdata[pwmc_pkg::B_PAIR1_CORRECTION_SELECT]     = s_q.sel_b[0];
                    s_d.rdata[pwmc_pkg::B_PAIR2_CORRECTION_SELECT]     = s_q.sel_b[1];
                    s_d.rdata[pwmc_pkg::B_PAIR3_CORRECTION_SELECT]     = s_q.sel_b[2];
                    s_d.rdata[pwmc_pkg::B_LDFQ +: 2] = s_q.ldfq_b;
                end
                pwmc_pkg::A_CNTH: begin
                    s_d.rdata   = {4'h0, s_q.cnt[11:8]};
                    s_d.lat     = s_q.cnt[7:0];
                    s_d.lat_vld = 1'b1;
                end
                pwmc_pkg::A_CNTL: begin
                    s_d.rdata   = s_q.lat_vld ? s_q.lat : s_q.cnt[7:0];
                    s_d.lat_vld = 1'b0;
                end
                pwmc_pkg::A_MODH: s_d.rdata = {4'h0, s_q.mod_b[11:8]};
                pwmc_pkg::A_MODL: s_d.rdata = s_q.mod_b[7:0];
                pwmc_pkg::A_DEAD: s_d.rdata = s_q.dead;
                default: begin
                    for (int c = 0; c < 6; c++) begin
                        if (addr == 5'(pwmc_pkg::A_DUTY0 + 2 * c)) begin
                            s_d.rdata = s_q.duty_b[c][15:8];
                        end
                        if (addr == 5'(pwmc_pkg::A_DUTY0 + 2 * c + 1)) begin
                            s_d.rdata = s_q.duty_b[c][7:0];
                        end
                    end
                end
            endcase
        end

        if (wr) begin
            case (addr)
                pwmc_pkg::A_CTL1: begin
                    s_d.en   = wdata[pwmc_pkg::B_EN];
                    s_d.load_ok = wdata[pwmc_pkg::B_LOAD_OK];
                    s_d.irqe = wdata[pwmc_pkg::B_IRQE];
                    s_d.bank_y_soft_disable = wdata[pwmc_pkg::B_BANK_Y_SOFT_DISABLE];
                    s_d.bank_x_soft_disable = wdata[pwmc_pkg::B_BANK_X_SOFT_DISABLE];
                    if (!wdata[pwmc_pkg::B_FLAG] && s_q.armed && clr_ok) begin
                        s_d.flag = 1'b0;
                    end
                    s_d.armed = 1'b0;
                end
                pwmc_pkg::A_CTL2: begin
                    s_d.prsc_b   = wdata[pwmc_pkg::B_PRSC +: 2];
                    s_d.sel_b[0] = wdata[pwmc_pkg::B_PAIR1_CORRECTION_SELECT];
                    s_d.sel_b[1] = wdata[pwmc_pkg::B_PAIR2_CORRECTION_SELECT];
                    s_d.sel_b[2] = wdata[pwmc_pkg::B_PAIR3_CORRECTION_SELECT];
                    s_d.ldfq_b   = wdata[pwmc_pkg::B_LDFQ +: 2];
                end
                pwmc_pkg::A_MODH: s_d.mod_b[11:8] = wdata[3:0];
                pwmc_pkg::A_MODL: s_d.mod_b[7:0] = wdata;
                pwmc_pkg::A_DEAD: begin
                    if (!s_q.dead_wr) begin
                        s_d.dead    = wdata;
                        s_d.dead_wr = 1'b1;
                    end
                end
                default: begin
                    for (int c = 0; c < 6; c++) begin
                        if (addr == 5'(pwmc_pkg::A_DUTY0 + 2 * c)) begin
                            s_d.duty_b[c][15:8] = wdata;
                        end
                        if (addr == 5'(pwmc_pkg::A_DUTY0 + 2 * c + 1)) begin
                            s_d.duty_b[c][7:0] = wdata;
                        end
                    end
                end
            endcase
        end
        en_rise = s_d.en && !s_q.en;

        if (!s_q.en) begin
            s_d.cnt     = 12'h000;
            s_d.pre_cnt = 3'h0;
            s_d.dir_dn  = 1'b0;
            s_d.ld_cnt  = 3'h0;
        end else if (!break_mode) begin
            tick        = s_q.pre_cnt == 3'((4'h1 << s_q.prsc_a) - 4'h1);
            s_d.pre_cnt = tick ? 3'h0 : 3'(s_q.pre_cnt + 3'h1);
            if (tick) begin
                if (s_q.mod_a == 12'h000) begin
                    s_d.cnt = 12'(s_q.cnt - 12'h001);
                    cyc     = s_q.cnt == 12'h000;
                end else if (center_aligned) begin
                    if (!s_q.dir_dn) begin
                        if (s_q.cnt >= 12'(s_q.mod_a - 12'h001)) begin
                            s_d.cnt    = s_q.mod_a;
                            s_d.dir_dn = 1'b1;
                        end else begin
                            s_d.cnt = 12'(s_q.cnt + 12'h001);
                        end
                    end else if (s_q.cnt <= 12'h001) begin
                        s_d.cnt    = 12'h000;
                        s_d.dir_dn = 1'b0;
                        cyc        = 1'b1;
                    end else begin
                        s_d.cnt = 12'(s_q.cnt - 12'h001);
                    end
                end else if (s_q.cnt >= 12'(s_q.mod_a - 12'h001)) begin
                    s_d.cnt = 12'h000;
                    cyc     = 1'b1;
                end else begin
                    s_d.cnt = 12'(s_q.cnt + 12'h001);
                end
            end
            if (cyc) begin
                reload     = s_q.ld_cnt == 3'((4'h1 << s_q.ldfq_a) - 4'h1);
                s_d.ld_cnt = reload ? 3'h0 : 3'(s_q.ld_cnt + 3'h1);
            end
        end

        if (en_rise) begin
            reload = 1'b1;
        end
        if (reload) begin
            s_d.flag   = 1'b1;
            s_d.armed  = 1'b0;
            s_d.ldfq_a = s_d.ldfq_b;
            if (s_d.load_ok) begin
                s_d.mod_a  = s_d.mod_b;
                s_d.prsc_a = s_d.prsc_b;
                s_d.duty_a = s_d.duty_b;
            end
            s_d.load_ok = 1'b0;
        end
        if (cyc || en_rise) begin
            s_d.sel_a = s_d.sel_b;
        end

        case (s_q.st)
            pwmc_pkg::ST_OFF: begin
                if (en_rise) begin
                    s_d.st = (s_d.prsc_a != 2'b00) ? pwmc_pkg::ST_HOLD : pwmc_pkg::ST_RUN;
                end
            end
            pwmc_pkg::ST_HOLD: begin
                if (cyc) begin
                    s_d.st = pwmc_pkg::ST_RUN;
                end
            end
            pwmc_pkg::ST_RUN: s_d.st = pwmc_pkg::ST_RUN;
            default: s_d.st = pwmc_pkg::ST_OFF;
        endcase
        if (!s_d.en) begin
            s_d.st = pwmc_pkg::ST_OFF;
        end

        if (!break_mode) begin
            mask        = (s_d.bank_x_soft_disable ? disable_map_x : 6'h00) | (s_d.bank_y_soft_disable ? disable_map_y : 6'h00);
            s_d.sw_mask = mask | (cyc ? 6'h00 : s_q.sw_mask);
            for (int c = 0; c < 6; c++) begin
                dv = s_q.duty_a[c];
                if (complementary_mode) begin
                    dv = s_q.duty_a[(c / 2) * 2 + (s_q.sel_a[c / 2] ? 1 : 0)];
                end
                act[c] = s_q.en && !dv[15] && (dv != 16'h0000)
                         && ((dv >= {4'h0, s_q.mod_a}) || ({4'h0, s_q.cnt} < dv));
            end
            for (int p = 0; p < 3; p++) begin
                g[p] = act[2 * p];
                if (g[p] != s_q.gen_prev[p]) begin
                    s_d.dt_cnt[p]   = s_q.dead;
                    s_d.gen_prev[p] = g[p];
                end else if (s_q.dt_cnt[p] != 8'h00) begin
                    s_d.dt_cnt[p] = 8'(s_q.dt_cnt[p] - 8'h01);
                end
                dt0[p]       = s_d.dt_cnt[p] == 8'h00;
                raw[2 * p]     = complementary_mode ? (g[p] && dt0[p]) : act[2 * p];
                raw[2 * p + 1] = complementary_mode ? (s_q.en && !g[p] && dt0[p]) : act[2 * p + 1];
            end
            if (manual_output_control) begin
                raw = manual_out;
            end
            s_d.out = raw & ~fault_disable & ~s_d.sw_mask;
            // pins float unless in run state or manual
            live    = manual_output_control || (s_d.st == pwmc_pkg::ST_RUN);
            s_d.oe  = live ? 6'h3f : 6'h00;
        end else begin
            s_d.out = s_q.out & ~fault_disable;
            live    = 1'b0;
        end
        s_d.irq = s_d.flag && s_d.irqe;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else if (clk_en && !stop_mode) begin
            s_q <= s_d;
        end
    end

    assign rdata      = s_q.rdata;
    assign pwm_out    = s_q.out;
    assign pwm_oe     = s_q.oe;
    assign reload_irq = s_q.irq;

    logic step;
    assign step = clk_en && !stop_mode;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_STOP_FREEZE: assert property (stop_mode |=> $stable(s_q))
        else $error("state moved in stop mode");
    AST_BREAK_CNT: assert property (step && break_mode && !wr |=> $stable(s_q.cnt) && $stable(s_q.dead))
        else $error("counter moved in break");
    AST_BREAK_FAULT: assert property ($past(step) |-> (pwm_out & $past(fault_disable)) == 6'h00)
        else $error("faulted pin driven active");
    AST_FLAG_GUARD: assert property (step && break_mode && !break_clear_enable && s_q.flag |=> s_q.flag)
        else $error("flag cleared in break");
    AST_IRQ_TIE: assert property (step |=> reload_irq == $past(s_d.flag && s_d.irqe))
        else $error("interrupt not tied to flag");
    AST_DEAD_ONCE: assert property (step && s_q.dead_wr |=> s_q.dead == $past(s_q.dead))
        else $error("dead time rewritten");
    AST_LOAD_OK_SELF: assert property (step && reload |=> !s_q.load_ok && s_q.flag)
        else $error("load-ok not cleared at reload");
    AST_MOD_HOLD: assert property (step && !reload |=> s_q.mod_a == $past(s_q.mod_a))
        else $error("modulus changed without reload");
    AST_RD_ONCE: assert property (step && !rd |=> rdata == 8'h00)
        else $error("read data outside answer cycle");
    AST_EN_FLOAT: assert property (step && !wr && !s_q.en && !manual_output_control && !break_mode
                                   |=> pwm_oe == 6'h00)
        else $error("pins driven while disabled");

endmodule // motor_pwm_control_logic

// ### verif/motor_pwm_control_logic_tb_top.sv
// Purpose: Self-checking bench for the motor PWM control logic
// Assumes: Edge-aligned counting unless a test selects otherwise
// Notes:   Pulse widths are counted at the power stage inputs
module motor_pwm_control_logic_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic       sys_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       clk_en = 1'b1;
    logic [4:0] addr = 5'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] rdata;
    logic       stop_mode = 1'b0;
    logic       break_mode = 1'b0;
    logic       break_clear_enable = 1'b0;
    logic       complementary_mode = 1'b0;
    logic       center_aligned = 1'b0;
    logic [5:0] disable_map_x = 6'h00;
    logic [5:0] disable_map_y = 6'h00;
    logic [5:0] fault_disable = 6'h00;
    logic       manual_output_control = 1'b0;
    logic [5:0] manual_out = 6'h00;
    logic [5:0] pwm_out;
    logic [5:0] pwm_oe;
    logic       reload_irq;
    logic [5:0] pin_level;
    logic       shoot_through_q;
    int         errors = 0;
    int         comparisons = 0;
    int         n;
    logic [7:0] lo;
    logic [5:0] v;

    always #2.5 sys_clk = ~sys_clk;

    motor_pwm_control_logic motor_pwm_control_logic_i (
        .sys_clk, .rst_n, .clk_en, .addr, .wdata, .wr, .rd, .rdata, .stop_mode, .break_mode,
        .break_clear_enable, .complementary_mode, .center_aligned, .disable_map_x, .disable_map_y,
        .fault_disable, .manual_output_control, .manual_out, .pwm_out, .pwm_oe, .reload_irq);

    power_stage_model power_stage_model_i (.sys_clk, .rst_n, .pwm_out, .pwm_oe, .pin_level, .shoot_through_q);

    task automatic give_verdict();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        rd_reg(a, d);
        chk(what, {8'h00, exp}, {8'h00, d});
    endtask

    task automatic wr16(input logic [4:0] a, input logic [15:0] val);
        wr_reg(a, val[15:8]);
        wr_reg(a + 5'd1, val[7:0]);
    endtask

    task automatic edges(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    // Bit 6 selects the interrupt line; a fresh rise needs a low sample first
    task automatic wait_rise(input int b, output int k);
        logic p;
        logic s;
        p = 1'b1;
        k = 0;
        repeat (600) begin
            edges(1);
            k++;
            s = (b == 6) ? reload_irq : pin_level[b];
            if (s === 1'b1 && p === 1'b0) return;
            p = s;
        end
        errors++;
        $display("MISMATCH rise on line %0d expected within 600 seen none", b);
    endtask

    // Third rise only, so a reload in flight never skews the figure
    task automatic period(input int b, output int k);
        repeat (3) wait_rise(b, k);
    endtask

    task automatic high_cnt(input int b, input int span, output int k);
        k = 0;
        repeat (span) begin
            edges(1);
            k += int'(pin_level[b]);
        end
    endtask

    task automatic clear_flag();
        logic [7:0] d;
        rd_reg(pwmc_pkg::A_CTL1, d);
        wr_reg(pwmc_pkg::A_CTL1, 8'h21);
    endtask

    task automatic t_reset_and_regs();
        rd_chk(pwmc_pkg::A_CTL1, 8'h00, "ctl1_rst");
        rd_chk(pwmc_pkg::A_DEAD, 8'h00, "dead_rst");
        chk("oe_rst", 16'h0000, {10'h000, pwm_oe});
        wr_reg(5'h1f, 8'ha5);
        rd_chk(5'h1f, 8'h00, "unmapped");
        wr16(pwmc_pkg::A_MODH, 16'h0008);
        wr16(pwmc_pkg::A_DUTY0, 16'h0004);
        wr16(pwmc_pkg::A_DUTY0 + 5'd4, 16'h0010);
        wr16(pwmc_pkg::A_DUTY0 + 5'd6, 16'hfff0);
        rd_chk(pwmc_pkg::A_MODL, 8'h08, "mod_buf");
        rd_chk(pwmc_pkg::A_DUTY0 + 5'd7, 8'hf0, "duty_buf");
        wr_reg(pwmc_pkg::A_CTL2, 8'h04);
        rd_chk(pwmc_pkg::A_CTL2, 8'h00, "ctl2_rsv");
        wr_reg(pwmc_pkg::A_DEAD, 8'h05);
        wr_reg(pwmc_pkg::A_DEAD, 8'h09);
        rd_chk(pwmc_pkg::A_DEAD, 8'h05, "dead_once");
    endtask

    task automatic t_enable_and_shape();
        int hi[4] = '{4, 0, 8, 0};
        wr_reg(pwmc_pkg::A_CTL1, 8'h03);
        #1;
        chk("oe_on", 16'h003f, {10'h000, pwm_oe});
        rd_chk(pwmc_pkg::A_CTL1, 8'h11, "ctl1_on");
        chk("irq_masked", 16'h0000, {15'h0000, reload_irq});
        wr_reg(pwmc_pkg::A_CTL1, 8'h31);
        edges(2);
        chk("irq_on", 16'h0001, {15'h0000, reload_irq});
        wr_reg(pwmc_pkg::A_CTL1, 8'h11);
        edges(2);
        chk("irq_inhibit", 16'h0000, {15'h0000, reload_irq});
        wr_reg(pwmc_pkg::A_CTL1, 8'h31);
        period(0, n);
        chk("period_edge", 16'd8, 16'(n));
        for (int c = 0; c < 4; c++) begin
            high_cnt(c, 8, n);
            chk("high_time", 16'(hi[c]), 16'(n));
        end
    endtask

    task automatic t_buffers();
        wr16(pwmc_pkg::A_MODH, 16'h000c);
        period(0, n);
        chk("mod_held", 16'd8, 16'(n));
        wr_reg(pwmc_pkg::A_CTL1, 8'h33);
        period(0, n);
        chk("mod_new", 16'd12, 16'(n));
        rd_chk(pwmc_pkg::A_CTL1, 8'h31, "load_ok_clr");
        wr_reg(pwmc_pkg::A_CTL2, 8'h01);
        wr_reg(pwmc_pkg::A_CTL1, 8'h33);
        period(0, n);
        chk("prescale", 16'd24, 16'(n));
        wr_reg(pwmc_pkg::A_CTL2, 8'h00);
        wr_reg(pwmc_pkg::A_CTL1, 8'h33);
        center_aligned <= 1'b1;
        period(0, n);
        chk("period_center", 16'd24, 16'(n));
        center_aligned <= 1'b0;
    endtask

    task automatic t_break();
        @(posedge sys_clk);
        break_mode <= 1'b1;
        edges(2);
        v = pwm_out;
        edges(20);
        chk("frozen", {10'h000, v}, {10'h000, pwm_out});
        rd_reg(pwmc_pkg::A_CNTL, lo);
        rd_chk(pwmc_pkg::A_CNTH, 8'h00, "cnt_high");
        @(posedge sys_clk);
        break_mode <= 1'b0;
        edges(3);
        @(posedge sys_clk);
        break_mode <= 1'b1;
        rd_chk(pwmc_pkg::A_CNTL, lo, "cnt_latch");
        clear_flag();
        rd_chk(pwmc_pkg::A_CTL1, 8'h31, "flag_kept");
        @(posedge sys_clk);
        break_clear_enable <= 1'b1;
        clear_flag();
        rd_chk(pwmc_pkg::A_CTL1, 8'h21, "flag_cleared");
        @(posedge sys_clk);
        fault_disable <= 6'h3f;
        edges(2);
        chk("fault_break", 16'h0000, {10'h000, pwm_out});
        @(posedge sys_clk);
        fault_disable      <= 6'h00;
        break_mode         <= 1'b0;
        break_clear_enable <= 1'b0;
    endtask

    task automatic t_disable_and_reload();
        @(posedge sys_clk);
        disable_map_x <= 6'h04;
        wr_reg(pwmc_pkg::A_CTL1, 8'ha1);
        edges(2);
        chk("dis_set", 16'h0000, {15'h0000, pwm_out[2]});
        wait_rise(0, n);
        wr_reg(pwmc_pkg::A_CTL1, 8'h21);
        edges(1);
        chk("dis_hold", 16'h0000, {15'h0000, pwm_out[2]});
        wait_rise(0, n);
        chk("dis_release", 16'h0001, {15'h0000, pwm_out[2]});
        for (int c = 0; c < 4; c++) begin
            wr_reg(pwmc_pkg::A_CTL2, 8'(c << 6));
            clear_flag();
            wait_rise(6, n);
            clear_flag();
            wait_rise(6, n);
            chk("reload_gap", 16'(12 << c), 16'(n + 4));
        end
        wr_reg(pwmc_pkg::A_CTL1, 8'h21);
        rd_chk(pwmc_pkg::A_CTL1, 8'h31, "flag_unread");
        clear_flag();
        rd_chk(pwmc_pkg::A_CTL1, 8'h21, "flag_read_clr");
        wr_reg(pwmc_pkg::A_CTL2, 8'h00);
    endtask

    task automatic t_complementary();
        wr16(pwmc_pkg::A_MODH, 16'h0020);
        wr16(pwmc_pkg::A_DUTY0, 16'h0010);
        wr16(pwmc_pkg::A_DUTY0 + 5'd2, 16'h0008);
        wr_reg(pwmc_pkg::A_CTL1, 8'h23);
        complementary_mode <= 1'b1;
        edges(70);
        high_cnt(0, 32, n);
        chk("comp_even", 16'd11, 16'(n));
        high_cnt(1, 32, n);
        chk("comp_odd", 16'd11, 16'(n));
        wr_reg(pwmc_pkg::A_CTL2, 8'h20);
        edges(70);
        high_cnt(0, 32, n);
        chk("sel_even", 16'd3, 16'(n));
        high_cnt(1, 32, n);
        chk("sel_odd", 16'd19, 16'(n));
        chk("overlap", 16'h0000, {15'h0000, shoot_through_q});
    endtask

    task automatic t_stop();
        @(posedge sys_clk);
        clk_en <= 1'b0;
        edges(2);
        v = pwm_out;
        edges(40);
        chk("clk_frozen", {10'h000, v}, {10'h000, pwm_out});
        @(posedge sys_clk);
        clk_en <= 1'b1;
        // Enable dropped before stop so the stage is never left driven
        wr_reg(pwmc_pkg::A_CTL1, 8'h00);
        #1;
        chk("oe_off", 16'h0000, {10'h000, pwm_oe});
        @(posedge sys_clk);
        stop_mode <= 1'b1;
        wr_reg(pwmc_pkg::A_CTL2, 8'h41);
        @(posedge sys_clk);
        stop_mode <= 1'b0;
        rd_chk(pwmc_pkg::A_CTL2, 8'h20, "stop_write");
        // Prescale of two holds the pins for one 64-edge cycle
        wr_reg(pwmc_pkg::A_CTL2, 8'h21);
        wr_reg(pwmc_pkg::A_CTL1, 8'h03);
        edges(8);
        chk("oe_hold", 16'h0000, {10'h000, pwm_oe});
        edges(62);
        chk("oe_late", 16'h003f, {10'h000, pwm_oe});
        wr16(pwmc_pkg::A_MODH, 16'h0000);
        wr_reg(pwmc_pkg::A_CTL1, 8'h03);
        edges(60);
        rd_chk(pwmc_pkg::A_CNTH, 8'h0f, "mod_zero");
        @(posedge sys_clk);
        manual_output_control <= 1'b1;
        manual_out            <= 6'h15;
        disable_map_y         <= 6'h01;
        edges(2);
        chk("manual", 16'h3f15, {2'b00, pwm_oe, 2'b00, pwm_out});
        wr_reg(pwmc_pkg::A_CTL1, 8'h41);
        #1;
        chk("dis_y", 16'h0014, {10'h000, pwm_out});
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset_and_regs();
        t_enable_and_shape();
        t_buffers();
        t_break();
        t_disable_and_reload();
        t_complementary();
        t_stop();
        give_verdict();
    end

    // Whole run is a few thousand cycles; forty thousand means a hang
    initial begin
        #200000;
        errors++;
        give_verdict();
    end
endmodule // motor_pwm_control_logic_tb_top

// ### verif/power_stage_model.sv
// Purpose: Power stage seen by the six PWM pins
// Assumes: Gate inputs are pulled down while a pin floats
// Notes:   Latches any pair whose two switches are on together
module power_stage_model (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic [5:0] pwm_out,
    input  wire logic [5:0] pwm_oe,
    output      logic [5:0] pin_level,
    output      logic       shoot_through_q
);
    timeunit 1ns;
    timeprecision 1ps;

    // A floating pin settles at the pull-down level, never the last value
    assign pin_level = pwm_oe & pwm_out;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            shoot_through_q <= 1'b0;
        end else if (|(pin_level[4:0] & pin_level[5:1] & 5'h15)) begin
            shoot_through_q <= 1'b1;
        end
    end
endmodule // power_stage_model
